// ==== tcw_timer.v ====
// 8-bit timer: counter, two compare units, waveform modes, pin override.
// Assumes an AHB-Lite master, a single-cycle timer_tick enable from a
// prescaler, and synchronous inputs on sys_clk.
//
// Contract
// R1 - Reset clears compare output state to zero
// R2 - Mode field selects next-match state action
// R3 - Nonzero mode field puts state on pin
// R4 - Direction bit alone controls pin driver
// R5 - Pin override independent of waveform mode
// R6 - State may be preset before pin enabled (code: channel A only, and not in fast PWM)
// R7 - Mode zero leaves state unchanged on match
// R8 - New mode acts from next match on
// R9 - Force strobe applies action immediately non-PWM
// R10 - Waveform mode alone sets counting sequence
// R11 - Mode 0 counts up, wraps FF to 00
// R12 - Normal overflow flag set when count zero
// R13 - Overflow flag cleared on interrupt service
// R14 - Count writable at any time in normal
// R15 - Mode 2 clears count on compare A
// R16 - CLEAR_ON_MATCH_MODE compare A writes unbuffered, may miss
// R17 - CLEAR_ON_MATCH_MODE raises compare A flag at top
// R18 - CLEAR_ON_MATCH_MODE mode 1 toggles output A
// R19 - CLEAR_ON_MATCH_MODE overflow flag set at MAX to 00
// R20 - Modes 3 and 7 are fast PWM
// R21 - Fast PWM clear/set on match, bottom (code: channel A in mode 7 skips the match action and acts at bottom only)
// R22 - Fast PWM counts to top, then zero
// R23 - Match raises flag next tick, W1C
// R24 - Count write blocks next tick matches
// R25 - PWM compare writes buffered until bottom
// R26 - Force strobe ignored in PWM modes
// R27 - No tick holds count and outputs
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "tcw_defs.vh"

module tcw_timer
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire timer_tick,
    input wire ovf_int_ack,
    input wire cmpa_int_ack,
    input wire cmpb_int_ack,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [1:0] pin_out,
    output reg [1:0] pin_oe,
    output reg overflow_flag_o,
    output reg compare_flag_a_o,
    output reg compare_flag_b_o
);

// ==========================================================
// State
reg [2:0] waveform_mode_q;
reg tick_en_q;
reg [1:0] compare_output_mode_a_q;
reg [1:0] compare_output_mode_b_q;
reg [7:0] count_value_q;
reg [7:0] compare_value_a_q;
reg [7:0] compare_value_b_q;
reg [7:0] cmp_buf_a_q;
reg [7:0] cmp_buf_b_q;
reg overflow_flag_q;
reg compare_flag_a_q;
reg compare_flag_b_q;
reg [1:0] compare_output_state_q;
reg [1:0] port_out_q;
reg [1:0] port_dir_q;
reg block_q;
reg match_a_q;
reg match_b_q;
reg wr_pend_q;
reg [7:0] wr_addr_q;

// ==========================================================
// Bus decode
wire tick = timer_tick & tick_en_q;
wire addr_ph = hsel & hready & htrans[1];
wire wr_now = wr_pend_q;
wire [31:0] wd = hwdata;
wire wr_ctrl = wr_now & (wr_addr_q == `TCW_OFS_CTRL);
wire wr_cnt = wr_now & (wr_addr_q == `TCW_OFS_COUNT);
wire wr_cmpa = wr_now & (wr_addr_q == `TCW_OFS_CMPA);
wire wr_cmpb = wr_now & (wr_addr_q == `TCW_OFS_CMPB);
wire wr_flg = wr_now & (wr_addr_q == `TCW_OFS_FLAGS);
wire wr_port = wr_now & (wr_addr_q == `TCW_OFS_PORT);

// ==========================================================
// Mode decode
wire is_fast = (waveform_mode_q == `TCW_WGM_FAST_FF) |
    (waveform_mode_q == `TCW_WGM_FAST_A); // R20
wire is_ctc = (waveform_mode_q == `TCW_WGM_CTC);
wire [7:0] top_val = (is_ctc | (waveform_mode_q == `TCW_WGM_FAST_A)) ?
    compare_value_a_q : `TCW_MAX; // R10
wire at_top = (count_value_q == top_val);
wire match_a = (count_value_q == compare_value_a_q) & ~block_q; // R24
wire match_b = (count_value_q == compare_value_b_q) & ~block_q; // R24
wire [7:0] next_count = (is_ctc | is_fast) & at_top ?
    `TCW_BOTTOM : count_value_q + 8'h01; // R11 R15 R22
// Outside fast PWM only a pass from MAX counts as overflow; a CLEAR_ON_MATCH_MODE clear at top does not
wire wrap = (count_value_q == `TCW_MAX); // R12 R19

// ==========================================================
// Per-channel compare output logic
wire [1:0] com [0:1];
wire [1:0] mtch;
wire [1:0] force_s;
wire [1:0] oc_d;
assign com[0] = compare_output_mode_a_q;
assign com[1] = compare_output_mode_b_q;
assign mtch = {match_b, match_a};
assign force_s = {wd[`TCW_CTRL_FOCB_BIT], wd[`TCW_CTRL_FOCA_BIT]};

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_oc
        reg nx;
        always @*
        begin
            nx = compare_output_state_q[g];
            if (is_fast)
            begin
                // Toggle option only on channel A with mode 7
                if (tick & mtch[g] & (com[g] == 2'b01) & (g == 0) &
                    waveform_mode_q[2])
                    nx = ~nx;
                else if (tick & mtch[g] & com[g][1] &
                    ~((g == 0) & waveform_mode_q[2]))
                    nx = com[g][0]; // R21
                else if (tick & at_top & com[g][1])
                    nx = ~com[g][0]; // R21
            end
            else if ((tick & mtch[g]) |
                (wr_ctrl & force_s[g])) // R9 R26
            begin
                case (com[g]) // R2 R7 R8 R18
                    2'b01: nx = ~nx;
                    2'b10: nx = 1'b0;
                    2'b11: nx = 1'b1;
                    default: nx = nx;
                endcase
            end
        end
        assign oc_d[g] = nx;
    end
endgenerate

// ==========================================================
// Registers
always @(posedge sys_clk)
begin
    if (rst)
    begin
        waveform_mode_q <= `TCW_WGM_NORMAL;
        tick_en_q <= 1'b0;
        compare_output_mode_a_q <= 2'b00;
        compare_output_mode_b_q <= 2'b00;
        count_value_q <= `TCW_BOTTOM;
        compare_value_a_q <= `TCW_BOTTOM;
        compare_value_b_q <= `TCW_BOTTOM;
        cmp_buf_a_q <= `TCW_BOTTOM;
        cmp_buf_b_q <= `TCW_BOTTOM;
        overflow_flag_q <= 1'b0;
        compare_flag_a_q <= 1'b0;
        compare_flag_b_q <= 1'b0;
        compare_output_state_q <= 2'b00; // R1
        port_out_q <= 2'b00;
        port_dir_q <= 2'b00;
        block_q <= 1'b0;
        match_a_q <= 1'b0;
        match_b_q <= 1'b0;
        wr_pend_q <= 1'b0;
        wr_addr_q <= 8'h00;
        hrdata <= `TCW_RST_WORD;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        pin_out <= 2'b00;
        pin_oe <= 2'b00;
        overflow_flag_o <= 1'b0;
        compare_flag_a_o <= 1'b0;
        compare_flag_b_o <= 1'b0;
    end
    else if (clk_en)
    begin
        // Bus address phase; zero wait states, always OKAY
        wr_pend_q <= addr_ph & hwrite;
        wr_addr_q <= {haddr[7:2], 2'b00};
        if (addr_ph & ~hwrite)
        begin
            case ({haddr[7:2], 2'b00})
                `TCW_OFS_CTRL: hrdata <= {24'h00_0000,
                    compare_output_mode_a_q, compare_output_mode_b_q,
                    tick_en_q, waveform_mode_q};
                `TCW_OFS_COUNT: hrdata <= {24'h00_0000, count_value_q};
                `TCW_OFS_CMPA: hrdata <= {24'h00_0000,
                    is_fast ? cmp_buf_a_q : compare_value_a_q};
                `TCW_OFS_CMPB: hrdata <= {24'h00_0000,
                    is_fast ? cmp_buf_b_q : compare_value_b_q};
                `TCW_OFS_FLAGS: hrdata <= {27'h000_0000,
                    compare_output_state_q, compare_flag_b_q,
                    compare_flag_a_q, overflow_flag_q};
                `TCW_OFS_PORT: hrdata <= {28'h000_0000, port_dir_q,
                    port_out_q};
                default: hrdata <= `TCW_RST_WORD;
            endcase
        end
        if (wr_ctrl)
        begin
            waveform_mode_q <= wd[2:0]; // R10
            tick_en_q <= wd[`TCW_CTRL_TICK_EN_BIT];
            compare_output_mode_b_q <= wd[5:4];
            compare_output_mode_a_q <= wd[7:6]; // R8
        end
        if (wr_port)
        begin
            port_out_q <= wd[1:0];
            port_dir_q <= wd[3:2];
        end
        // Preset of the channel A state while its mode field is zero, outside fast PWM
        if (wr_flg & ~is_fast & (compare_output_mode_a_q == 2'b00))
            compare_output_state_q <= {oc_d[1], wd[`TCW_FLG_OCA_BIT]}; // R6
        else
            compare_output_state_q <= oc_d;
        // Count; software write has priority
        if (wr_cnt)
            count_value_q <= wd[7:0]; // R14
        else if (tick)
            count_value_q <= next_count; // R27
        // Block spans until the next tick has passed
        if (wr_cnt)
            block_q <= 1'b1; // R24
        else if (tick)
            block_q <= 1'b0;
        // Compare registers: direct or buffered
        if (wr_cmpa)
            cmp_buf_a_q <= wd[7:0];
        if (wr_cmpb)
            cmp_buf_b_q <= wd[7:0];
        if (~is_fast)
        begin
            if (wr_cmpa)
                compare_value_a_q <= wd[7:0]; // R16 R25
            if (wr_cmpb)
                compare_value_b_q <= wd[7:0]; // R25
        end
        else if (tick & at_top)
        begin
            compare_value_a_q <= cmp_buf_a_q; // R25
            compare_value_b_q <= cmp_buf_b_q;
        end
        // Match seen at one tick sets flag at the next
        if (tick)
        begin
            match_a_q <= match_a;
            match_b_q <= match_b;
        end
        // Flags: set wins over clear
        if (tick & (is_fast ? at_top : wrap))
            overflow_flag_q <= 1'b1; // R12 R19
        else if (ovf_int_ack | (wr_flg & wd[`TCW_FLG_OVF_BIT]))
            overflow_flag_q <= 1'b0; // R13
        if (tick & match_a_q)
            compare_flag_a_q <= 1'b1; // R17 R23
        else if (cmpa_int_ack | (wr_flg & wd[`TCW_FLG_CMPA_BIT]))
            compare_flag_a_q <= 1'b0; // R23
        if (tick & match_b_q)
            compare_flag_b_q <= 1'b1; // R23
        else if (cmpb_int_ack | (wr_flg & wd[`TCW_FLG_CMPB_BIT]))
            compare_flag_b_q <= 1'b0; // R23
        // Pin mux; direction stays with the port
        pin_out[0] <= (compare_output_mode_a_q != 2'b00) ?
            oc_d[0] : port_out_q[0]; // R3 R5
        pin_out[1] <= (compare_output_mode_b_q != 2'b00) ?
            oc_d[1] : port_out_q[1]; // R3 R5
        pin_oe <= port_dir_q; // R4
        overflow_flag_o <= overflow_flag_q;
        compare_flag_a_o <= compare_flag_a_q;
        compare_flag_b_o <= compare_flag_b_q;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

endmodule

// ==== tcw_defs.vh ====
// Constants for the 8-bit timer compare and waveform block.
// Included by tcw_timer.v; holds definitions only.
`ifndef TCW_DEFS_VH
`define TCW_DEFS_VH
// ==========================================================
// Register byte offsets
`define TCW_OFS_CTRL 8'h00
`define TCW_OFS_COUNT 8'h04
`define TCW_OFS_CMPA 8'h08
`define TCW_OFS_CMPB 8'h0C
`define TCW_OFS_FLAGS 8'h10
`define TCW_OFS_PORT 8'h14
// ==========================================================
// Control register fields
`define TCW_CTRL_WGM_LSB 0
`define TCW_CTRL_TICK_EN_BIT 3
`define TCW_CTRL_COMB_LSB 4
`define TCW_CTRL_COMA_LSB 6
`define TCW_CTRL_FOCB_BIT 8
`define TCW_CTRL_FOCA_BIT 9
// ==========================================================
// Flags register fields
`define TCW_FLG_OVF_BIT 0
`define TCW_FLG_CMPA_BIT 1
`define TCW_FLG_CMPB_BIT 2
`define TCW_FLG_OCA_BIT 3
`define TCW_FLG_OCB_BIT 4
// ==========================================================
// Port register fields
`define TCW_PORT_OUT_LSB 0
`define TCW_PORT_DIR_LSB 2
// ==========================================================
// Waveform modes and values
`define TCW_WGM_NORMAL 3'h0
`define TCW_WGM_CTC 3'h2
`define TCW_WGM_FAST_FF 3'h3
`define TCW_WGM_FAST_A 3'h7
`define TCW_MAX 8'hFF
`define TCW_BOTTOM 8'h00
`define TCW_RST_WORD 32'h0000_0000
`endif

// ==== tcw_timer_props.sv ====
// Checker for the timer's port timing, bound to tcw_timer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
// ==========================================================
// Port checker
module tcw_props
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire timer_tick,
    input wire ovf_int_ack,
    input wire cmpa_int_ack,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [1:0] pin_out,
    input wire [1:0] pin_oe,
    input wire overflow_flag_o,
    input wire compare_flag_a_o
);
    logic wr_q;
    // Write data phase; registers land at its closing edge
    always @(posedge sys_clk)
    begin
        if (rst)
            wr_q <= 1'h0;
        else if (clk_en)
            wr_q <= hsel & hready & htrans[1] & hwrite;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_rst;
        $fell(rst) |-> pin_out == 2'h0 && pin_oe == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("pins not reset");
    property p_dir;
        !$stable(pin_oe) |-> $past(wr_q) || $past(wr_q, 2);
    endproperty
    a_dir: assert property (p_dir) else $error("pin_oe moved");
    property p_hold;
        !$stable(pin_out) |-> $past(wr_q) || $past(wr_q, 2)
            || $past(timer_tick) || $past(timer_tick, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("pin_out moved");
    property p_cfa;
        $rose(compare_flag_a_o) |-> $past(timer_tick, 2);
    endproperty
    a_cfa: assert property (p_cfa) else $error("cmp flag early");
    property p_ovf;
        $rose(overflow_flag_o) |-> $past(timer_tick, 2);
    endproperty
    a_ovf: assert property (p_ovf) else $error("ovf flag early");
    property p_ovf_ack;
        ovf_int_ack && !timer_tick ##1 !timer_tick |=> !overflow_flag_o;
    endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("ovf kept");
    property p_cfa_ack;
        cmpa_int_ack && !timer_tick ##1 !timer_tick |=> !compare_flag_a_o;
    endproperty
    a_cfa_ack: assert property (p_cfa_ack) else $error("cmp kept");
    property p_bus;
        hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not ready");
endmodule

bind tcw_timer tcw_props u_props (.sys_clk, .rst, .clk_en, .timer_tick,
    .ovf_int_ack, .cmpa_int_ack, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .pin_out, .pin_oe, .overflow_flag_o,
    .compare_flag_a_o);

// ==== tcw_pin_model.sv ====
// Port pad model fed by the timer's pin outputs.
// Assumes no pull on the pad; a released pad must not look stable.
`timescale 1ns/100ps
// ==========================================================
// Pad model
module tcw_pin_model
(
    input wire sys_clk,
    input wire [1:0] pin_out,
    input wire [1:0] pin_oe,
    output logic [1:0] pad
);
    logic [1:0] float_q = 2'h1;
    always @(posedge sys_clk)
        float_q <= ~float_q;
    assign pad = (pin_oe & pin_out) | (~pin_oe & float_q);
endmodule

// ==== tcw_tb.sv ====
// Testbench: AHB-Lite scenarios against a reference count model.
// Assumes tcw_timer with its checker bound, and the pad model.
`timescale 1ns/100ps
`include "tcw_defs.vh"
// ==========================================================
// Bench top
module testbench;
    logic sys_clk = 0, rst = 1, timer_tick = 0, ovf_int_ack = 0;
    logic cmpa_int_ack = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdat;
    wire [31:0] hrdata;
    wire hreadyout, hresp, overflow_flag_o, compare_flag_a_o;
    wire compare_flag_b_o;
    wire [1:0] pin_out, pin_oe, pad;
    int fail_count = 0, tests_run = 0, cyc = 0, m_cnt, m_top, m_mode;
    int seed = 32'h9a78_177b;
    always #5 sys_clk = ~sys_clk;
    tcw_timer dut_u (.sys_clk, .rst, .clk_en(1'h1), .timer_tick,
        .ovf_int_ack, .cmpa_int_ack, .cmpb_int_ack(1'h0), .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .pin_out, .pin_oe, .overflow_flag_o,
        .compare_flag_a_o, .compare_flag_b_o);
    tcw_pin_model pin_u (.sys_clk, .pin_out, .pin_oe, .pad);
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        @(posedge sys_clk iff hreadyout === 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk iff hreadyout === 1'h1);
        rdat = hrdata;
    endtask
    task automatic rchk(string nm, logic [7:0] a, logic [31:0] m,
        logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk(nm, e, rdat & m);
    endtask
    // Reference count advances once per delivered tick
    task automatic tk(int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            timer_tick <= 1'h1;
            @(posedge sys_clk);
            timer_tick <= 1'h0;
            if (m_mode >= 0)
                m_cnt = (m_mode == 2 && m_cnt == m_top) ? 0 : (m_cnt + 1) % 256;
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the roughly 150 cycles needed
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        chk("pin_out", 32'h0000_0000, pin_out);
        chk("cmpb_o", 32'h0000_0000, compare_flag_b_o);
        rchk("flags", `TCW_OFS_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_0008);
        m_mode = 0;
        m_cnt = $random(seed) & 255;
        bus(1'h1, `TCW_OFS_COUNT, m_cnt);
        rchk("count", `TCW_OFS_COUNT, 32'h0000_00FF, m_cnt);
        m_cnt = 253;
        bus(1'h1, `TCW_OFS_COUNT, m_cnt);
        tk(3);
        rchk("count", `TCW_OFS_COUNT, 32'h0000_00FF, m_cnt);
        rchk("ovf", `TCW_OFS_FLAGS, 32'h0000_0001, 32'h0000_0001);
        chk("ovf_o", 32'h0000_0001, overflow_flag_o);
        @(posedge sys_clk);
        ovf_int_ack <= 1'h1;
        @(posedge sys_clk);
        ovf_int_ack <= 1'h0;
        rchk("ovf", `TCW_OFS_FLAGS, 32'h0000_0001, 32'h0000_0000);
        $display("END normal");
        bus(1'h1, `TCW_OFS_PORT, 32'h0000_0004);
        bus(1'h1, `TCW_OFS_FLAGS, 32'h0000_0008);
        rchk("state", `TCW_OFS_FLAGS, 32'h0000_0008, 32'h0000_0008);
        chk("pin_out", 32'h0000_0000, pin_out);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_0048);
        repeat (3) @(posedge sys_clk);
        chk("pin_out", 32'h0000_0001, pin_out);
        chk("pin_oe", 32'h0000_0001, pin_oe);
        chk("pad", 32'h0000_0001, pad);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_0248);
        rchk("state", `TCW_OFS_FLAGS, 32'h0000_0008, 32'h0000_0000);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_004B);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_024B);
        rchk("state", `TCW_OFS_FLAGS, 32'h0000_0008, 32'h0000_0000);
        $display("END force");
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_004A);
        m_mode = 2;
        m_top = 3;
        bus(1'h1, `TCW_OFS_CMPA, m_top);
        m_cnt = 0;
        bus(1'h1, `TCW_OFS_COUNT, m_cnt);
        bus(1'h1, `TCW_OFS_FLAGS, 32'h0000_0007);
        tk(5);
        rchk("count", `TCW_OFS_COUNT, 32'h0000_00FF, m_cnt);
        chk("cmpa_o", 32'h0000_0001, compare_flag_a_o);
        rchk("flags", `TCW_OFS_FLAGS, 32'h0000_000B, 32'h0000_000A);
        @(posedge sys_clk);
        cmpa_int_ack <= 1'h1;
        @(posedge sys_clk);
        cmpa_int_ack <= 1'h0;
        rchk("cmpa", `TCW_OFS_FLAGS, 32'h0000_0002, 32'h0000_0000);
        tk(2);
        m_top = 1;
        bus(1'h1, `TCW_OFS_CMPA, m_top);
        tk(3);
        rchk("count", `TCW_OFS_COUNT, 32'h0000_00FF, m_cnt);
        bus(1'h1, `TCW_OFS_CTRL, 32'h0000_0042);
        m_mode = -1;
        tk(3);
        rchk("count", `TCW_OFS_COUNT, 32'h0000_00FF, m_cnt);
        rchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("END ctc");
        final_report();
    end
endmodule
